// >>> dic_pkg.sv
// shared constants and types for the digital input conditioner
package dic_pkg;
   localparam int unsigned NUM_INPUTS = 8;
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned TICK_US = 250;
   localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
   localparam int unsigned MAX_FILTER_US = 65000;
   localparam int unsigned MAX_TICKS = MAX_FILTER_US / TICK_US;
   localparam int unsigned TICK_CNT_W = 14;
   localparam int unsigned DEB_CNT_W = 9;
   localparam logic [TICK_CNT_W-1:0] TICK_LAST = 14'(TICK_CYCLES - 1);
   localparam logic [DEB_CNT_W-1:0] DEB_MAX = 9'(MAX_TICKS);
   localparam int unsigned FUNC_W = 3;
   localparam logic [FUNC_W-1:0] FN_OFF = 3'h0;
   localparam logic [FUNC_W-1:0] FN_GENERIC = 3'h1;
   localparam logic [FUNC_W-1:0] FN_UPPER_LIMIT = 3'h2;
   localparam logic [FUNC_W-1:0] FN_LOWER_LIMIT = 3'h3;
   localparam logic [FUNC_W-1:0] FN_HOMING = 3'h4;
   localparam logic [FUNC_W-1:0] FN_OTHER = 3'h5;
   // register map, byte addresses
   localparam logic [11:0] REG_IMAGE = 12'h000;
   localparam logic [11:0] REG_INTERVAL = 12'h004;
   localparam logic [11:0] REG_FILTER_MASK = 12'h008;
   localparam logic [11:0] REG_INVERSION = 12'h00c;
   localparam logic [11:0] REG_TERMINATION = 12'h010;
   localparam logic [11:0] REG_FUNCTION = 12'h014;
   localparam logic [11:0] REG_LIMIT_STATE = 12'h018;
   localparam logic [11:0] REG_EFF_CONFIG = 12'h01c;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [DEB_CNT_W-1:0] RST_INTERVAL = 9'h000;
   localparam logic [31:0] RST_FUNCTION = 32'h00000000;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } dic_apb_req_t;
   typedef struct packed {
      logic upper;
      logic lower;
   } dic_limit_t;
endpackage : dic_pkg

// >>> dic_conditioner.sv
// digital input conditioner with apb configuration
`timescale 1ns/100ps
module dic_conditioner (
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // physical inputs
   input wire logic [7:0] din_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // conditioned outputs
   output logic [7:0] input_image_o,
   output logic [7:0] line_termination_enable_o,
   output logic [1:0] travel_limit_state_o
);
   localparam int unsigned N = dic_pkg::NUM_INPUTS;
   localparam int unsigned CW = dic_pkg::DEB_CNT_W;

   dic_pkg::dic_apb_req_t req;
   assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i, paddr: paddr_i, pwdata: pwdata_i};

   // pins are asynchronous, two stages before use
   logic [N-1:0] sync1_q;
   logic [N-1:0] sync2_q;
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= din_i;
         sync2_q <= sync1_q;
      end
   end

   logic [dic_pkg::TICK_CNT_W-1:0] tick_cnt_q;
   logic tick_q;
   wire tick_wrap = (tick_cnt_q == dic_pkg::TICK_LAST);
   wire [dic_pkg::TICK_CNT_W-1:0] tick_cnt_d = tick_wrap ? '0 : tick_cnt_q + 1'b1;
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
      end
      else
      begin
         tick_cnt_q <= tick_cnt_d;
         tick_q <= tick_wrap;
      end
   end

   // configuration registers
   logic [CW-1:0] interval_q;
   logic [N-1:0] filter_select_mask_q;
   logic [N-1:0] input_inversion_mask_q;
   logic [N-1:0] termination_q;
   logic [31:0] function_q;

   // apb decode
   wire access = req.psel & req.penable;
   wire wr_en = access & req.pwrite;
   wire sel_image = (req.paddr == dic_pkg::REG_IMAGE);
   wire sel_interval = (req.paddr == dic_pkg::REG_INTERVAL);
   wire sel_mask = (req.paddr == dic_pkg::REG_FILTER_MASK);
   wire sel_inv = (req.paddr == dic_pkg::REG_INVERSION);
   wire sel_term = (req.paddr == dic_pkg::REG_TERMINATION);
   wire sel_func = (req.paddr == dic_pkg::REG_FUNCTION);
   wire sel_limit = (req.paddr == dic_pkg::REG_LIMIT_STATE);
   wire sel_eff = (req.paddr == dic_pkg::REG_EFF_CONFIG);
   wire mapped = sel_image | sel_interval | sel_mask | sel_inv | sel_term | sel_func | sel_limit | sel_eff;
   // writes above 65 ms saturate, whole word compared
   wire [CW-1:0] interval_wr = (req.pwdata > 32'(dic_pkg::MAX_TICKS)) ? dic_pkg::DEB_MAX : req.pwdata[CW-1:0];
   // per-register write strobes
   wire wr_interval = wr_en & sel_interval;
   wire wr_mask = wr_en & sel_mask;
   wire wr_inv = wr_en & sel_inv;
   wire wr_term = wr_en & sel_term;
   wire wr_func = wr_en & sel_func;

   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         interval_q <= dic_pkg::RST_INTERVAL;
         filter_select_mask_q <= dic_pkg::RST_MASK;
         input_inversion_mask_q <= dic_pkg::RST_MASK;
         termination_q <= dic_pkg::RST_MASK;
         function_q <= dic_pkg::RST_FUNCTION;
      end
      else
      begin
         if (wr_interval)
            interval_q <= interval_wr;
         if (wr_mask)
            filter_select_mask_q <= req.pwdata[N-1:0];
         if (wr_inv)
            input_inversion_mask_q <= req.pwdata[N-1:0];
         if (wr_term)
            termination_q <= req.pwdata[N-1:0];
         if (wr_func)
            function_q <= req.pwdata;
      end
   end

   // per-input function decode
   logic [N-1:0] is_limit;
   logic [N-1:0] filter_allowed;
   logic [N-1:0] is_upper;
   logic [N-1:0] is_lower;
   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_fn
         wire [dic_pkg::FUNC_W-1:0] fn = function_q[4*g +: dic_pkg::FUNC_W];
         assign is_upper[g] = (fn == dic_pkg::FN_UPPER_LIMIT);
         assign is_lower[g] = (fn == dic_pkg::FN_LOWER_LIMIT);
         assign is_limit[g] = is_upper[g] | is_lower[g];
         wire is_generic = (fn == dic_pkg::FN_GENERIC);
         wire is_homing = (fn == dic_pkg::FN_HOMING);
         assign filter_allowed[g] = is_generic | is_limit[g] | is_homing;
      end
   endgenerate

   wire [N-1:0] eff_inversion = input_inversion_mask_q & ~is_limit;
   wire [N-1:0] eff_filter = filter_select_mask_q & filter_allowed;

   // one snapshot of the pins per tick
   logic [N-1:0] sample_q;
   logic eval_q;
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         sample_q <= '0;
         eval_q <= 1'b0;
      end
      else
      begin
         if (tick_q)
            sample_q <= sync2_q;
         eval_q <= tick_q;
      end
   end

   // debounce state, one cell per input
   logic [N-1:0] stable_bits;
   logic [N-1:0] pass_through;
   logic [N-1:0] restart;
   logic [N-1:0] settled;
   logic [N-1:0] reached;
   // an interval of one tick commits on the first differing sample
   wire single_tick = (interval_q == CW'(1));
   assign pass_through = ~eff_filter | {N{interval_q == CW'(0)}};

   genvar d;
   generate
      for (d = 0; d < N; d++)
      begin : g_deb
         logic candidate_q;
         logic stable_q;
         logic [CW-1:0] deb_cnt_q;
         wire [CW-1:0] cnt_next = deb_cnt_q + CW'(1);
         assign restart[d] = (sample_q[d] != candidate_q);
         assign settled[d] = (candidate_q == stable_q);
         assign reached[d] = (cnt_next >= interval_q);
         assign stable_bits[d] = stable_q;
         // state moves only once per snapshot
         always_ff @(posedge mclk_i or posedge sys_rst_i)
         begin
            if (sys_rst_i)
            begin
               candidate_q <= 1'b0;
               stable_q <= 1'b0;
               deb_cnt_q <= '0;
            end
            else if (eval_q)
            begin
               if (pass_through[d])
               begin
                  stable_q <= sample_q[d];
                  candidate_q <= sample_q[d];
                  deb_cnt_q <= '0;
               end
               else if (restart[d])
               begin
                  candidate_q <= sample_q[d];
                  deb_cnt_q <= CW'(1);
                  if (single_tick)
                     stable_q <= sample_q[d];
               end
               else if (settled[d])
               begin
                  deb_cnt_q <= '0;
               end
               else if (reached[d])
               begin
                  stable_q <= candidate_q;
                  deb_cnt_q <= '0;
               end
               else
                  deb_cnt_q <= cnt_next;
            end
         end
      end
   endgenerate

   wire [N-1:0] image_d = stable_bits ^ eff_inversion;
   // limit state is complement of input
   wire [N-1:0] upper_engaged = is_upper & ~image_d;
   wire [N-1:0] lower_engaged = is_lower & ~image_d;
   dic_pkg::dic_limit_t limit_d;
   assign limit_d.upper = |upper_engaged;
   assign limit_d.lower = |lower_engaged;

   wire [31:0] rdata_d =
      sel_image ? {24'h000000, input_image_o} :
      sel_interval ? {23'h0, interval_q} :
      sel_mask ? {24'h000000, filter_select_mask_q} :
      sel_inv ? {24'h000000, input_inversion_mask_q} :
      sel_term ? {24'h000000, termination_q} :
      sel_func ? function_q :
      sel_limit ? {30'h0, travel_limit_state_o} :
      sel_eff ? {16'h0000, eff_filter, eff_inversion} : 32'h00000000;

   // zero wait: pready registered in setup, so it stands through the one access cycle
   wire setup_phase = req.psel & ~req.penable;
   wire refuse = setup_phase & ~mapped;
   logic ready_q;
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         ready_q <= 1'b0;
         prdata_o <= '0;
         pslverr_o <= 1'b0;
      end
      else
      begin
         ready_q <= setup_phase;
         prdata_o <= rdata_d;
         pslverr_o <= refuse;
      end
   end
   assign pready_o = ready_q;

   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         input_image_o <= '0;
         line_termination_enable_o <= '0;
         travel_limit_state_o <= '0;
      end
      else
      begin
         input_image_o <= image_d;
         line_termination_enable_o <= termination_q;
         travel_limit_state_o <= {limit_d.upper, limit_d.lower};
      end
   end

endmodule : dic_conditioner

// >>> dic_switch_model.sv
// switch and sensor model driving the physical inputs
`timescale 1ns/100ps
module dic_switch_model (
   // clock
   input wire logic mclk_i,
   // wanted level and short excursions
   input wire logic [7:0] level_i,
   input wire logic [7:0] glitch_i,
   // pins
   output logic [7:0] din_o
);
   // limit sensors are normally closed, so the idle level here is an engaged limit
   always_ff @(posedge mclk_i)
   begin
      din_o <= level_i ^ glitch_i;
   end
endmodule : dic_switch_model

// >>> dic_conditioner_asserts.sv
// port checker for the digital input conditioner
`timescale 1ns/100ps
module dic_conditioner_asserts (
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // pins and apb
   input wire logic [7:0] din_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // outputs
   input wire logic [7:0] input_image_o,
   input wire logic [7:0] line_termination_enable_o,
   input wire logic [1:0] travel_limit_state_o
);
   wire logic [7:0] wr_low = pwdata_i[7:0];
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   sequence setup_s; psel_i && !penable_i; endsequence
   sequence access_s; psel_i && penable_i; endsequence
   ready_after_setup_a: assert property (setup_s |=> access_s ##0 pready_o)
      else $error("no ready after setup");
   ready_in_access_a: assert property (pready_o |-> access_s) else $error("ready outside access");
   ready_single_a: assert property (pready_o |=> !pready_o) else $error("ready too long");
   err_with_ready_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
   unmapped_err_a: assert property (pready_o && paddr_i > dic_pkg::REG_EFF_CONFIG |-> pslverr_o && prdata_o == 32'h0)
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (pready_o && paddr_i <= dic_pkg::REG_EFF_CONFIG && paddr_i[1:0] == 2'h0
      |-> !pslverr_o) else $error("mapped access refused");
   interval_cap_a: assert property (pready_o && !pwrite_i && paddr_i == dic_pkg::REG_INTERVAL
      |-> prdata_o <= 32'h104) else $error("interval above cap");
   term_copy_a: assert property (access_s ##0 pready_o && pwrite_i && paddr_i == dic_pkg::REG_TERMINATION
      |=> ##1 line_termination_enable_o == $past(wr_low, 2)) else $error("termination not copied");
   reset_zero_a: assert property ($fell(sys_rst_i)
      |-> input_image_o == 8'h00 && travel_limit_state_o == 2'h0 && !pready_o)
      else $error("outputs not clear after reset");
endmodule : dic_conditioner_asserts
bind dic_conditioner dic_conditioner_asserts chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .din_i(din_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .input_image_o(input_image_o),
   .line_termination_enable_o(line_termination_enable_o), .travel_limit_state_o(travel_limit_state_o));

// >>> digital_input_conditioner_test.sv
// self-checking testbench for the digital input conditioner
`timescale 1ns/100ps
module digital_input_conditioner_test;
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready;
   logic pslverr;
   logic er;
   logic [7:0] level = 8'h00;
   logic [7:0] glitch = 8'h00;
   logic [7:0] din;
   logic [7:0] image;
   logic [7:0] term;
   logic [1:0] lim;
   int error_cnt = 0;
   int total_checks = 0;
   initial forever #12.5 mclk_i = ~mclk_i;
   dic_switch_model sw (.mclk_i(mclk_i), .level_i(level), .glitch_i(glitch), .din_o(din));
   dic_conditioner uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .din_i(din), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .input_image_o(image), .line_termination_enable_o(term), .travel_limit_state_o(lim));
   task give_verdict;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one transfer; pready and read data are taken at rising edges only
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk_i);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      pen <= 1'b1;
      n = 0;
      @(posedge mclk_i);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge mclk_i);
         n++;
      end
      if (pready !== 1'b1)
      begin
         error_cnt++;
         give_verdict();
      end
      else
      begin
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         pen <= 1'b0;
      end
   endtask : apb
   task run(input int n);
      repeat (n) @(posedge mclk_i);
   endtask : run
   task test_reset;
      for (int i = 1; i < 8; i++)
      begin
         apb(1'b0, 12'(4 * i), 32'h0);
         if (i != 6)
            check(rd, 32'h0);
      end
      apb(1'b0, 12'h100, 32'h0);
      check(32'(er), 32'h1);
      check(rd, 32'h0);
      $display("reset test done");
   endtask : test_reset
   task test_config;
      apb(1'b1, dic_pkg::REG_FUNCTION, 32'h11154132);
      apb(1'b1, dic_pkg::REG_INVERSION, 32'hff);
      apb(1'b1, dic_pkg::REG_FILTER_MASK, 32'hff);
      apb(1'b1, dic_pkg::REG_INTERVAL, 32'h12c);
      apb(1'b0, dic_pkg::REG_INTERVAL, 32'h0);
      check(rd, 32'h104);
      apb(1'b1, dic_pkg::REG_INTERVAL, 32'h3);
      apb(1'b1, dic_pkg::REG_TERMINATION, 32'h5a);
      run(2);
      check(term, 8'h5a);
      apb(1'b0, dic_pkg::REG_EFF_CONFIG, 32'h0);
      check(rd, 32'heffc);
      run(12000);
      check(image, 8'hfc);
      check(lim, 2'h3);
      $display("config test done");
   endtask : test_config
   task test_glitch;
      glitch <= 8'h14;
      run(12000);
      check(image, 8'hec);
      glitch <= 8'h00;
      run(11000);
      check(image, 8'hfc);
      $display("glitch test done");
   endtask : test_glitch
   task test_commit;
      level <= 8'h05;
      run(15000);
      check(image, 8'hfc);
      run(25000);
      check(image, 8'hf9);
      apb(1'b0, dic_pkg::REG_LIMIT_STATE, 32'h0);
      check(rd, 32'h1);
      $display("commit test done");
   endtask : test_commit
   initial
   begin
      run(10);
      sys_rst_i <= 1'b0;
      test_reset();
      test_config();
      test_glitch();
      test_commit();
      give_verdict();
   end
endmodule : digital_input_conditioner_test
